// >>> ltrr_pkg.sv
// Constants, register map and helpers for the latency tolerance reporter.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
//
// How it works
// - Each function picks a minimum, maximum or no-requirement report.
// - All links down or all ports disabled, enables set: cleared message.
// - Otherwise the minimum value register contents are reported.
// - Sent values never exceed function 0 snoop and no-snoop limits.
// - Merged message carries lowest tolerance per traffic type, any function.
// - No function needing a traffic type leaves its requirement bit clear.
// - With capability enabled, send when merged value changes, after reset or on a forcing write.
// - Disabled function or messaging disabled counts as no requirement.
// - Supported bit and capability structure follow nonvolatile enable bit.
// - After fundamental reset and enable, a cleared message is sent.
// - Rx and tx disabled, rx buffer empty, port-disable enable: no requirement.
// - Link down, management traffic off, link-down enable: no requirement.
// - Not fully active power state: no requirement.
// - Minimum due but both its requirement flags clear: no requirement.
// - Maximum due but both its requirement flags clear: no requirement.
// - No-requirement wins; otherwise maximum register may be reported.
// - Writing 1 to request-maximum with request-minimum 0 sends a maximum message.
// - In maximum mode, new maximum register contents send a fresh message.
// - Maximum cleared: minimum sent only if smaller than maximum.
// - Writing 1 to request-minimum sends a minimum message.
// - New minimum contents send a fresh message unless overridden.
// - Init control word bit 13 advertises support; default 1 without memory.

package ltrr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int         ADDR_W       = 5;
   localparam logic [1:0] REG_CTRL     = 2'h0;
   localparam logic [1:0] REG_MINV     = 2'h1;
   localparam logic [1:0] REG_MAXV     = 2'h2;
   localparam logic [1:0] REG_STAT     = 2'h3;
   localparam logic [4:0] REG_MSG      = 5'h10;
   localparam int         GLOBAL_BIT   = 4;

   // Control bits
   localparam int CTRL_REQ_MIN = 0;
   localparam int CTRL_REQ_MAX = 1;
   localparam int CTRL_LD_EN   = 2;
   localparam int CTRL_PD_EN   = 3;

   // ****************************************
   // Latency field layout
   // ****************************************
   localparam int          FIELD_W      = 16;
   localparam int          VAL_LSB      = 0;
   localparam int          VAL_W        = 10;
   localparam int          SCALE_LSB    = 10;
   localparam int          SCALE_W      = 3;
   localparam int          REQ_BIT      = 15;
   localparam int          LIMIT_W      = 13;
   localparam int          NS_W         = 40;
   localparam logic [2:0]  SCALE_MAX    = 3'h5;
   localparam logic [15:0] FIELD_NONE   = 16'h0000;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   // Nonvolatile init control word bit, and its default
   localparam int   NVM_ADV_BIT = 13;
   localparam logic NVM_ADV_DEF = 1'b1;

   typedef enum logic [1:0]
   {
      KIND_NOREQ = 2'b00,
      KIND_MIN   = 2'b01,
      KIND_MAX   = 2'b10
   } ltrr_kind_t;

   // Latency of one field in ns units of value * 32^scale
   function automatic logic [NS_W-1:0] ltrr_ns(input logic [FIELD_W-1:0] f);
      logic [2:0]      sc;
      logic [NS_W-1:0] v;
      sc = f[SCALE_LSB +: SCALE_W];
      v  = {{(NS_W-VAL_W){1'b0}}, f[VAL_LSB +: VAL_W]};
      if (sc > SCALE_MAX)
         sc = SCALE_MAX;
      ltrr_ns = v << (5 * sc);
   endfunction : ltrr_ns

endpackage : ltrr_pkg

// >>> ltrr_func_if.sv
// Bundle between the reporter core and one per-function report selector.
// Assumes the core drives status and settings, the selector the report.
`timescale 1ns/1ns

interface ltrr_func_if;
   import ltrr_pkg::*;
   logic                   func_on;
   logic                   active_pwr;
   logic                   link_up;
   logic                   rx_en;
   logic                   tx_en;
   logic                   rx_empty;
   logic                   mgmt_en;
   logic                   ld_en;
   logic                   pd_en;
   logic                   max_mode;
   logic [2*FIELD_W-1:0]   minv;
   logic [2*FIELD_W-1:0]   maxv;
   ltrr_kind_t             kind;
   logic [2*FIELD_W-1:0]   report;

   modport core (output func_on, active_pwr, link_up, rx_en, tx_en,
                 rx_empty, mgmt_en, ld_en, pd_en, max_mode, minv, maxv,
                 input kind, report);
   modport sel  (input func_on, active_pwr, link_up, rx_en, tx_en,
                 rx_empty, mgmt_en, ld_en, pd_en, max_mode, minv, maxv,
                 output kind, report);
endinterface : ltrr_func_if

// >>> ltrr_func_sel.sv
// Per-function choice between no requirement, minimum and maximum report.
// Assumes settings come from registers held in the reporter core.
`timescale 1ns/1ns

module ltrr_func_sel
   import ltrr_pkg::*;
(
   // Function link
   ltrr_func_if.sel  f
);

   logic  noreq;
   logic  min_lt_max;
   logic  min_flags;
   logic  max_flags;

   // ****************************************
   // Report selection
   // ****************************************
   always_comb
   begin
      noreq = !f.func_on
            || !f.active_pwr
            || (!f.rx_en && !f.tx_en && f.rx_empty && f.pd_en)
            || (!f.link_up && !f.mgmt_en && f.ld_en);
      min_flags = f.minv[REQ_BIT] || f.minv[FIELD_W+REQ_BIT];
      max_flags = f.maxv[REQ_BIT] || f.maxv[FIELD_W+REQ_BIT];
      // Maximum without requirement flags bounds nothing
      min_lt_max = !max_flags
                 || (ltrr_ns(f.minv[FIELD_W-1:0])
                    < ltrr_ns(f.maxv[FIELD_W-1:0]))
                 || (ltrr_ns(f.minv[2*FIELD_W-1:FIELD_W])
                    < ltrr_ns(f.maxv[2*FIELD_W-1:FIELD_W]));
      f.kind   = KIND_MIN;
      f.report = f.minv;
      if (noreq)
      begin
         f.kind   = KIND_NOREQ;
         f.report = WORD_ZERO;
      end
      else if (f.max_mode || !min_lt_max)
      begin
         f.kind   = max_flags ? KIND_MAX : KIND_NOREQ;
         f.report = max_flags ? f.maxv : WORD_ZERO;
      end
      else if (!min_flags)
      begin
         f.kind   = KIND_NOREQ;
         f.report = WORD_ZERO;
      end
   end

endmodule : ltrr_func_sel

// >>> ltrr_reporter.sv
// Latency tolerance reporter core: registers, merge and message sender.
// Assumes status inputs synchronous to mclk; message taken on valid&ready.
`timescale 1ns/1ns

module ltrr_reporter
   import ltrr_pkg::*;
#(
   parameter int NUM_FUNC = 4
)
(
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // Register port
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // Per-function status
   input  wire logic [NUM_FUNC-1:0]   func_enabled,
   input  wire logic [NUM_FUNC-1:0]   fully_active_power_state,
   input  wire logic [NUM_FUNC-1:0]   link_up,
   input  wire logic [NUM_FUNC-1:0]   receive_enable_bit,
   input  wire logic [NUM_FUNC-1:0]   transmit_enable_bit,
   input  wire logic [NUM_FUNC-1:0]   rx_buffer_empty,
   input  wire logic [NUM_FUNC-1:0]   mgmt_to_host_traffic_enable,
   // Function 0 configuration space
   input  wire logic                  mech_enable,
   input  wire logic [LIMIT_W-1:0]    max_snoop_limit,
   input  wire logic [LIMIT_W-1:0]    max_nosnoop_limit,
   output logic                       mech_supported,
   output logic                       cap_struct_present,
   // Nonvolatile init control word
   input  wire logic                  nvm_load,
   input  wire logic [15:0]           nvm_init_ctrl1,
   // Upstream message
   output logic                       msg_valid,
   output logic      [2*FIELD_W-1:0]  msg_data,
   input  wire logic                  msg_ready
);

   localparam int FW = 2 * FIELD_W;

   initial
   begin
      if (NUM_FUNC < 1 || NUM_FUNC > 4)
         $error("NUM_FUNC must be 1 to 4");
   end

   // ****************************************
   // Register storage
   // ****************************************
   logic [NUM_FUNC-1:0]   max_mode_q;
   logic [NUM_FUNC-1:0]   ld_en_q;
   logic [NUM_FUNC-1:0]   pd_en_q;
   logic [FW-1:0]         minv_q [NUM_FUNC];
   logic [FW-1:0]         maxv_q [NUM_FUNC];
   logic                  advertise_q;
   logic                  force_q;
   logic                  force_d;
   logic                  reset_msg_q;
   logic                  msg_valid_q;
   logic [FW-1:0]         msg_data_q;
   logic [FW-1:0]         last_q;
   logic [31:0]           rdata_q;
   logic [31:0]           rdata_d;
   logic [FW-1:0]         merged;
   logic                  send_now;
   ltrr_kind_t            kind   [NUM_FUNC];
   logic [FW-1:0]         report [NUM_FUNC];

   // Address decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input int                fn,
                                input logic [1:0]        r);
      hit = !a[GLOBAL_BIT] && (a[3:2] == 2'(fn)) && (a[1:0] == r);
   endfunction : hit

   // ****************************************
   // Per-function registers and selectors
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_FUNC; g++)
      begin : g_fn
         ltrr_func_if fi ();

         assign fi.func_on    = func_enabled[g] && mech_enable;
         assign fi.active_pwr = fully_active_power_state[g];
         assign fi.link_up    = link_up[g];
         assign fi.rx_en      = receive_enable_bit[g];
         assign fi.tx_en      = transmit_enable_bit[g];
         assign fi.rx_empty   = rx_buffer_empty[g];
         assign fi.mgmt_en    = mgmt_to_host_traffic_enable[g];
         assign fi.ld_en      = ld_en_q[g];
         assign fi.pd_en      = pd_en_q[g];
         assign fi.max_mode   = max_mode_q[g];
         assign fi.minv       = minv_q[g];
         assign fi.maxv       = maxv_q[g];
         assign kind[g]       = fi.kind;
         assign report[g]     = fi.report;

         ltrr_func_sel u_sel
         (
            .f (fi.sel)
         );

         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               max_mode_q[g] <= 1'b0;
               ld_en_q[g]    <= 1'b0;
               pd_en_q[g]    <= 1'b0;
            end
            else if (reg_wr && hit(reg_addr, g, REG_CTRL))
            begin
               max_mode_q[g] <= reg_wdata[CTRL_REQ_MAX]
                                && !reg_wdata[CTRL_REQ_MIN];
               ld_en_q[g]    <= reg_wdata[CTRL_LD_EN];
               pd_en_q[g]    <= reg_wdata[CTRL_PD_EN];
            end
         end

         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               minv_q[g] <= WORD_ZERO;
               maxv_q[g] <= WORD_ZERO;
            end
            else
            begin
               if (reg_wr && hit(reg_addr, g, REG_MINV))
                  minv_q[g] <= reg_wdata;
               if (reg_wr && hit(reg_addr, g, REG_MAXV))
                  maxv_q[g] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ****************************************
   // Writes that demand a fresh message
   // ****************************************
   always_comb
   begin
      force_d = 1'b0;
      for (int i = 0; i < NUM_FUNC; i++)
      begin
         if (reg_wr && hit(reg_addr, i, REG_CTRL)
             && reg_wdata[CTRL_REQ_MAX] && kind[i] != KIND_NOREQ)
            force_d = 1'b1;
         if (reg_wr && hit(reg_addr, i, REG_CTRL)
             && reg_wdata[CTRL_REQ_MIN])
            force_d = 1'b1;
         if (reg_wr && hit(reg_addr, i, REG_MAXV)
             && reg_wdata != maxv_q[i] && kind[i] == KIND_MAX)
            force_d = 1'b1;
         if (reg_wr && hit(reg_addr, i, REG_MINV)
             && reg_wdata != minv_q[i] && kind[i] == KIND_MIN)
            force_d = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         force_q <= 1'b0;
      else if (force_d && mech_enable)
         force_q <= 1'b1;
      else if (send_now)
         force_q <= 1'b0;
   end

   // ****************************************
   // Merge across functions
   // ****************************************
   // All functions without requirement leave both fields cleared
   always_comb
   begin
      logic [FIELD_W-1:0] snp;
      logic [FIELD_W-1:0] nsnp;
      logic [FIELD_W-1:0] lim;
      snp  = FIELD_NONE;
      nsnp = FIELD_NONE;
      lim  = FIELD_NONE;
      for (int i = 0; i < NUM_FUNC; i++)
      begin
         if (report[i][REQ_BIT] && (!snp[REQ_BIT]
             || ltrr_ns(report[i][FIELD_W-1:0]) < ltrr_ns(snp)))
            snp = report[i][FIELD_W-1:0];
         if (report[i][FIELD_W+REQ_BIT] && (!nsnp[REQ_BIT]
             || ltrr_ns(report[i][FW-1:FIELD_W]) < ltrr_ns(nsnp)))
            nsnp = report[i][FW-1:FIELD_W];
      end
      lim = {3'h0, max_snoop_limit};
      if (snp[REQ_BIT] && ltrr_ns(snp) > ltrr_ns(lim))
         snp = {1'b1, 2'h0, max_snoop_limit};
      lim = {3'h0, max_nosnoop_limit};
      if (nsnp[REQ_BIT] && ltrr_ns(nsnp) > ltrr_ns(lim))
         nsnp = {1'b1, 2'h0, max_nosnoop_limit};
      if (!snp[REQ_BIT])
         snp = FIELD_NONE;
      if (!nsnp[REQ_BIT])
         nsnp = FIELD_NONE;
      merged = {nsnp, snp};
   end

   // ****************************************
   // Message sender
   // ****************************************
   assign send_now = mech_enable
                     && (reset_msg_q || force_q || merged != last_q);

   always_ff @(posedge mclk)
   begin
      if (srst)
         reset_msg_q <= 1'b1;
      else if (send_now)
         reset_msg_q <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         msg_valid_q <= 1'b0;
         msg_data_q  <= WORD_ZERO;
         last_q      <= WORD_ZERO;
      end
      else if (send_now)
      begin
         msg_valid_q <= 1'b1;
         msg_data_q  <= reset_msg_q ? WORD_ZERO : merged;
         last_q      <= reset_msg_q ? WORD_ZERO : merged;
      end
      else if (msg_ready)
         msg_valid_q <= 1'b0;
   end

   // ****************************************
   // Support advertisement
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (srst)
         advertise_q <= NVM_ADV_DEF;
      else if (nvm_load)
         advertise_q <= nvm_init_ctrl1[NVM_ADV_BIT];
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mech_supported     <= NVM_ADV_DEF;
         cap_struct_present <= NVM_ADV_DEF;
      end
      else
      begin
         mech_supported     <= advertise_q;
         cap_struct_present <= advertise_q;
      end
   end

   // ****************************************
   // Register read-back
   // ****************************************
   always_comb
   begin
      rdata_d = WORD_ZERO;
      if (reg_addr == REG_MSG)
         rdata_d = last_q;
      for (int i = 0; i < NUM_FUNC; i++)
      begin
         if (hit(reg_addr, i, REG_CTRL))
            rdata_d = {28'h0, pd_en_q[i], ld_en_q[i], max_mode_q[i], 1'b0};
         if (hit(reg_addr, i, REG_MINV))
            rdata_d = minv_q[i];
         if (hit(reg_addr, i, REG_MAXV))
            rdata_d = maxv_q[i];
         if (hit(reg_addr, i, REG_STAT))
            rdata_d = {30'h0, kind[i]};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         rdata_q <= WORD_ZERO;
      else if (reg_rd)
         rdata_q <= rdata_d;
      else
         rdata_q <= WORD_ZERO;
   end

   assign reg_rdata = rdata_q;
   assign msg_valid = msg_valid_q;
   assign msg_data  = msg_data_q;

endmodule : ltrr_reporter

// >>> ltrr_reporter_asserts.sv
// Checker on the latency reporter top ports.
// Assumes one clock mclk and synchronous active-high reset srst.
`timescale 1ns/1ns

module ltrr_reporter_asserts
   import ltrr_pkg::*;
(
   // Clock and reset
   input wire logic                 mclk,
   input wire logic                 srst,
   // Register port
   input wire logic [ADDR_W-1:0]    reg_addr,
   input wire logic [31:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   // Configuration
   input wire logic                 mech_enable,
   input wire logic [LIMIT_W-1:0]   max_snoop_limit,
   input wire logic [LIMIT_W-1:0]   max_nosnoop_limit,
   input wire logic                 mech_supported,
   input wire logic                 cap_struct_present,
   input wire logic                 nvm_load,
   input wire logic [15:0]          nvm_init_ctrl1,
   // Message link
   input wire logic                 msg_valid,
   input wire logic [2*FIELD_W-1:0] msg_data,
   input wire logic                 msg_ready
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // Latency in ns of a limit-style field
   function automatic logic [39:0] lat(input logic [12:0] f);
      logic [2:0] s;
      s   = (f[12:10] > 3'h5) ? 3'h5 : f[12:10];
      lat = {30'h0, f[9:0]} << (5 * s);
   endfunction : lat

   sequence s_req_wr;
      reg_wr && !reg_addr[4] && reg_addr[1:0] == 2'h0
         && reg_wdata[1:0] != 2'h0 && mech_enable;
   endsequence
   sequence s_held;
      msg_valid && !msg_ready;
   endsequence

   a_req_send: assert property (s_req_wr |=> ##1 msg_valid)
      else $error("request write sent no message");
   a_valid_hold: assert property (s_held |=> msg_valid)
      else $error("message dropped before taken");
   a_off_quiet: assert property (!mech_enable && !msg_valid |=> !msg_valid)
      else $error("message sent while disabled");
   a_snoop_limit: assert property (msg_valid && msg_data[15]
      |-> lat(msg_data[12:0]) <= lat(max_snoop_limit))
      else $error("snoop value above limit");
   a_nosnoop_limit: assert property (msg_valid && msg_data[31]
      |-> lat(msg_data[28:16]) <= lat(max_nosnoop_limit))
      else $error("no-snoop value above limit");
   a_adv_load: assert property (nvm_load |-> ##2
      mech_supported == $past(nvm_init_ctrl1[NVM_ADV_BIT], 2))
      else $error("advertise bit not loaded");
   a_cap_pair: assert property (cap_struct_present == mech_supported)
      else $error("capability structure and supported bit differ");
   a_reset_clear: assert property ($fell(srst) && mech_enable
      |-> ##[0:2] (msg_valid && msg_data == 32'h0))
      else $error("no cleared message after reset");
   a_min_wonly: assert property (reg_rd && !reg_addr[4]
      && reg_addr[1:0] == 2'h0 |=> !reg_rdata[0])
      else $error("request minimum bit reads back");
   a_rd_window: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule : ltrr_reporter_asserts

// >>> ltrr_root_model.sv
// Model of the upstream port that takes latency messages.
// Assumes a message is taken on msg_valid and msg_ready at mclk.
`timescale 1ns/1ns

module ltrr_root_model
   import ltrr_pkg::*;
(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // Pace control
   input  wire logic                 stall,
   input  wire logic                 slow,
   // Message link
   input  wire logic                 msg_valid,
   input  wire logic [2*FIELD_W-1:0] msg_data,
   output logic                      msg_ready,
   // Taken messages
   output logic                      got,
   output logic      [2*FIELD_W-1:0] got_data
);
   logic [1:0] pace_q;

   always_ff @(posedge mclk)
   begin
      if (srst)
         pace_q <= 2'h0;
      else
         pace_q <= pace_q + 2'h1;
   end

   // Ready at once, or one cycle in four
   assign msg_ready = !stall && (!slow || pace_q == 2'h3);

   always_ff @(posedge mclk)
   begin
      got      <= msg_valid && msg_ready && !srst;
      got_data <= msg_data;
   end
endmodule : ltrr_root_model

// >>> ltrr_reporter_tb.sv
// Self-checking bench for the latency tolerance reporter.
// Assumes checker and root model are compiled before it.
`timescale 1ns/1ns

module ltrr_reporter_tb
   import ltrr_pkg::*;
;
   localparam int NF = 4;
   logic          mclk = 1'b0;
   logic          srst = 1'b1;
   logic [4:0]    reg_addr = 5'h00;
   logic [31:0]   reg_wdata = 32'h0;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [31:0]   reg_rdata;
   logic [NF-1:0] fen = 4'hF, pwr = 4'hF, lnk = 4'hF, rxe = 4'hF;
   logic [NF-1:0] txe = 4'hF, rxm = 4'hF, mgt = 4'hF;
   logic          mech = 1'b1;
   logic [12:0]   snl = 13'h17FF;
   logic [12:0]   nsl = 13'h17FF;
   logic          sup, cap, nvm_load = 1'b0;
   logic [15:0]   nvm_ctl = 16'h0;
   logic          msg_valid, msg_ready, got, stall = 1'b0, slow = 1'b0;
   logic [31:0]   msg_data, got_data, mn, mx;
   logic          rd_q = 1'b0;
   logic [31:0]   mq[$];
   logic [31:0]   rq[$];
   int            failures = 0;
   int            num_checks = 0;

   always #5 mclk = ~mclk;

   ltrr_reporter #(.NUM_FUNC(NF)) ltrr_reporter_i
   (
      .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .func_enabled(fen), .fully_active_power_state(pwr), .link_up(lnk),
      .receive_enable_bit(rxe), .transmit_enable_bit(txe),
      .rx_buffer_empty(rxm), .mgmt_to_host_traffic_enable(mgt),
      .mech_enable(mech), .max_snoop_limit(snl), .max_nosnoop_limit(nsl),
      .mech_supported(sup), .cap_struct_present(cap),
      .nvm_load(nvm_load), .nvm_init_ctrl1(nvm_ctl),
      .msg_valid(msg_valid), .msg_data(msg_data), .msg_ready(msg_ready)
   );

   ltrr_root_model ltrr_root_model_i
   (
      .mclk(mclk), .srst(srst), .stall(stall), .slow(slow),
      .msg_valid(msg_valid), .msg_data(msg_data), .msg_ready(msg_ready),
      .got(got), .got_data(got_data)
   );

   // ****************************************
   // Checking
   // ****************************************
   task automatic bad(input string s);
      failures++;
      $display("unexpected %s at %0t", s, $time);
   endtask : bad

   task automatic chk_msg(input logic [31:0] v);
      num_checks++;
      if (mq.size() == 0)
         bad("message");
      else if (v !== mq.pop_front())
         bad("message data");
   endtask : chk_msg

   task automatic chk_rd(input logic [31:0] v);
      num_checks++;
      if (v !== rq.pop_front())
         bad("read data");
   endtask : chk_rd

   task automatic chk_bit(input logic v, input logic e);
      num_checks++;
      if (v !== e)
         bad("advertise bit");
   endtask : chk_bit

   always @(posedge mclk)
   begin
      if (got)
         chk_msg(got_data);
      if (rd_q)
         chk_rd(reg_rdata);
      rd_q <= reg_rd;
   end

   task automatic results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // ****************************************
   // Drivers
   // ****************************************
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      slow      <= 1'($urandom_range(1, 0));
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      rq.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : rd

   task automatic drain;
      int n;
      n = 0;
      while ((mq.size() != 0 || n < 6) && n < 60)
      begin
         @(posedge mclk);
         n++;
      end
      if (mq.size() != 0)
      begin
         bad("message timeout");
         mq.delete();
      end
   endtask : drain

   task automatic exp(input logic [31:0] e);
      mq.push_back(e);
      drain();
   endtask : exp

   function automatic logic [15:0] fld(input logic [9:0] v);
      fld = {6'h22, v};
   endfunction : fld

   initial
   begin
      #50000;
      bad("watchdog");
      results();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      logic [9:0] a;
      logic [9:0] b;
      void'($urandom(32'h746dfc06));
      a  = 10'h0C8 + 10'($urandom_range(799, 0));
      b  = 10'h0C8 + 10'($urandom_range(799, 0));
      mn = {fld(b), fld(a)};
      mx = {fld(b + 10'h00A), fld(a + 10'h00A)};
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      exp(32'h0);
      chk_bit(sup, 1'b1);
      rd(5'h1F, 32'h0);
      wr(5'h01, mn);
      exp(mn);
      rd(5'h01, mn);
      rd(5'h03, 32'h1);
      wr(5'h05, {fld(b + 10'h005), fld(a - 10'h005)});
      exp({fld(b), fld(a - 10'h005)});
      @(posedge mclk);
      fen[1] <= 1'b0;
      exp(mn);
      wr(5'h02, mx);
      drain();
      wr(5'h00, 32'h2);
      exp(mx);
      rd(5'h00, 32'h2);
      rd(5'h03, 32'h2);
      wr(5'h02, mx + 32'h1);
      exp(mx + 32'h1);
      wr(5'h02, mx & 32'h7FFF_7FFF);
      exp(32'h0);
      wr(5'h02, mx);
      exp(mx);
      wr(5'h00, 32'h0);
      exp(mn);
      wr(5'h01, mn & 32'h7FFF_7FFF);
      exp(32'h0);
      wr(5'h01, mn);
      exp(mn);
      wr(5'h00, 32'h1);
      exp(mn);
      @(posedge mclk);
      pwr[0] <= 1'b0;
      exp(32'h0);
      @(posedge mclk);
      pwr[0] <= 1'b1;
      exp(mn);
      wr(5'h00, 32'h4);
      @(posedge mclk);
      mgt[0] <= 1'b0;
      lnk[0] <= 1'b0;
      exp(32'h0);
      @(posedge mclk);
      lnk[0] <= 1'b1;
      exp(mn);
      wr(5'h00, 32'h8);
      @(posedge mclk);
      rxe[0] <= 1'b0;
      txe[0] <= 1'b0;
      rxm[0] <= 1'b0;
      drain();
      @(posedge mclk);
      rxm[0] <= 1'b1;
      exp(32'h0);
      @(posedge mclk);
      rxe[0] <= 1'b1;
      exp(mn);
      @(posedge mclk);
      snl <= {3'h2, a - 10'h003};
      exp({fld(b), 3'h4, 3'h2, a - 10'h003});
      @(posedge mclk);
      snl <= 13'h17FF;
      exp(mn);
      @(posedge mclk);
      stall <= 1'b1;
      wr(5'h01, mn + 32'h1);
      wr(5'h01, mn + 32'h2);
      @(posedge mclk);
      stall <= 1'b0;
      exp(mn + 32'h2);
      rd(5'h10, mn + 32'h2);
      @(posedge mclk);
      mech <= 1'b0;
      wr(5'h01, mn);
      drain();
      @(posedge mclk);
      mech <= 1'b1;
      exp(mn);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge mclk);
         nvm_load <= 1'b1;
         nvm_ctl  <= k[0] ? 16'h2000 : 16'h0000;
         @(posedge mclk);
         nvm_load <= 1'b0;
         @(posedge mclk);
         #1;
         chk_bit(sup, k[0]);
         chk_bit(cap, k[0]);
      end
      results();
   end
endmodule : ltrr_reporter_tb

bind ltrr_reporter ltrr_reporter_asserts ltrr_reporter_asserts_i
(
   .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mech_enable(mech_enable), .max_snoop_limit(max_snoop_limit),
   .max_nosnoop_limit(max_nosnoop_limit), .mech_supported(mech_supported),
   .cap_struct_present(cap_struct_present), .nvm_load(nvm_load),
   .nvm_init_ctrl1(nvm_init_ctrl1), .msg_valid(msg_valid),
   .msg_data(msg_data), .msg_ready(msg_ready)
);
